// File: rtl/ddcbn_pkg.sv
// Package: register map, field positions and reset values of the DDC config bank
package ddcbn_pkg;
    // Channel page bases on the 16-bit configuration address space
    localparam logic [15:0] CHAN_A_BASE = 16'h5000;
    localparam logic [15:0] CHAN_B_BASE = 16'h5800;
    // Printed register indices (not multiples of four), byte address = 4x
    localparam logic [7:0] IDX_BAND_COUNT_SELECT = 8'h02;
    localparam logic [7:0] IDX_OUTPUT_FORMAT_SELECT = 8'h05;
    localparam logic [7:0] IDX_INPUT_SOURCE_SELECT = 8'h06;
    localparam logic [7:0] IDX_B1_OSC1_LOW = 8'h07;
    localparam logic [7:0] IDX_B1_OSC1_HIGH = 8'h08;
    localparam logic [7:0] IDX_B1_OSC2_LOW = 8'h09;
    localparam logic [7:0] IDX_B1_OSC2_HIGH = 8'h0a;
    localparam logic [7:0] IDX_B1_OSC3_LOW = 8'h0b;
    localparam logic [7:0] IDX_B1_OSC3_HIGH = 8'h0c;
    // Extra read-only status word holding the assembled mode bits
    localparam logic [7:0] IDX_MODE_STATUS = 8'h20;
    // Byte offset of the channel B page inside the AXI window
    localparam logic [15:0] CHAN_B_AXI_OFS = 16'h0800;
    // Single-bit control field position
    localparam int CTRL_BIT = 0;
    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    // Word step of every oscillator frequency word is fs / 2^FREQ_BITS
    localparam int FREQ_BITS = 16;
    localparam int NUM_OSC = 3;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: rtl/ddcbn_chan_regs.sv
// One channel's configuration registers with read-back
`timescale 1ns/1ps
module ddcbn_chan_regs #(
    parameter bit DUAL_BAND_CAPABLE = 1'b1
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic wr_en_in,
    input wire logic [7:0] wr_idx_in,
    input wire logic [7:0] wr_data_in,
    input wire logic [7:0] rd_idx_in,
    output logic [7:0] rd_data_out,
    output logic rd_hit_out,
    output logic dual_band_out,
    output logic real_out_out,
    output logic cross_out,
    output logic [47:0] words_out
);
    logic dual_q;
    logic real_q;
    logic cross_q;
    logic [7:0] byte_q [0:5];
    logic [7:0] rd_d;
    logic hit_d;

    // Mode bits; dual band sticks at 0 on a single-band variant
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            dual_q <= 1'b0;
            real_q <= 1'b0;
            cross_q <= 1'b0;
        end
        else if (wr_en_in)
        begin
            if (wr_idx_in == ddcbn_pkg::IDX_BAND_COUNT_SELECT)
                dual_q <= wr_data_in[ddcbn_pkg::CTRL_BIT] & DUAL_BAND_CAPABLE;
            if (wr_idx_in == ddcbn_pkg::IDX_OUTPUT_FORMAT_SELECT)
                real_q <= wr_data_in[ddcbn_pkg::CTRL_BIT];
            if (wr_idx_in == ddcbn_pkg::IDX_INPUT_SOURCE_SELECT)
                cross_q <= wr_data_in[ddcbn_pkg::CTRL_BIT];
        end
    end

    // Six frequency bytes at consecutive indices, low before high
    genvar g;
    generate
        for (g = 0; g < 6; g++)
        begin : g_byte
            always_ff @(posedge clk_in)
            begin
                if (rst_in)
                    byte_q[g] <= ddcbn_pkg::RST_BYTE;
                else if (wr_en_in && wr_idx_in ==
                         ddcbn_pkg::IDX_B1_OSC1_LOW + 8'(g))
                    byte_q[g] <= wr_data_in;
            end
            assign words_out[g*8 +: 8] = byte_q[g];
        end
    endgenerate

    assign dual_band_out = dual_q;
    assign real_out_out = real_q;
    assign cross_out = cross_q;

    // Read decode; reserved bits read zero
    always_comb
    begin
        rd_d = 8'h00;
        hit_d = 1'b1;
        case (rd_idx_in)
            ddcbn_pkg::IDX_BAND_COUNT_SELECT: rd_d = {7'h00, dual_q};
            ddcbn_pkg::IDX_OUTPUT_FORMAT_SELECT: rd_d = {7'h00, real_q};
            ddcbn_pkg::IDX_INPUT_SOURCE_SELECT: rd_d = {7'h00, cross_q};
            ddcbn_pkg::IDX_B1_OSC1_LOW: rd_d = byte_q[0];
            ddcbn_pkg::IDX_B1_OSC1_HIGH: rd_d = byte_q[1];
            ddcbn_pkg::IDX_B1_OSC2_LOW: rd_d = byte_q[2];
            ddcbn_pkg::IDX_B1_OSC2_HIGH: rd_d = byte_q[3];
            ddcbn_pkg::IDX_B1_OSC3_LOW: rd_d = byte_q[4];
            ddcbn_pkg::IDX_B1_OSC3_HIGH: rd_d = byte_q[5];
            ddcbn_pkg::IDX_MODE_STATUS:
                rd_d = {5'h00, cross_q, real_q, dual_q};
            default: hit_d = 1'b0;
        endcase
    end

    // Registered read data
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            rd_data_out <= 8'h00;
            rd_hit_out <= 1'b0;
        end
        else
        begin
            rd_data_out <= rd_d;
            rd_hit_out <= hit_d;
        end
    end
endmodule // ddcbn_chan_regs

// File: rtl/ddcbn_route.sv
// Input routing and power control for the two channel converters
`timescale 1ns/1ps
module ddcbn_route (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic cross_a_in,
    input wire logic cross_b_in,
    output logic src_a_out,
    output logic src_b_out,
    output logic pwr_a_out,
    output logic pwr_b_out
);
    logic use_a_d;
    logic use_b_d;

    // Converter is needed if any DDC takes from it
    always_comb
    begin
        use_a_d = (!cross_a_in) | cross_b_in;
        use_b_d = (!cross_b_in) | cross_a_in;
    end

    // Source select: 0 own converter, 1 alternate
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            src_a_out <= 1'b0;
            src_b_out <= 1'b0;
            pwr_a_out <= 1'b1;
            pwr_b_out <= 1'b1;
        end
        else
        begin
            src_a_out <= cross_a_in;
            src_b_out <= cross_b_in;
            pwr_a_out <= use_a_d;
            pwr_b_out <= use_b_d;
        end
    end
endmodule // ddcbn_route

// File: rtl/ddcbn_top.sv
// AXI4-Lite register bank for DDC band, format, routing and osc words
//
// Contract
// - Dual-band bit: 0 single band, 1 dual
// - Real-output bit: 1 real at 2x, 0 complex
// - Routing bit: 1 alternate converter, 0 own
// - Both DDCs on one converter, other off
// - Osc1 word from low/high bytes, fs/2^16
// - Osc2 independent 16-bit word, two bytes
// - Osc3 word low byte then high byte
// - Page at 5000h channel A, 5800h B
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
module ddcbn_top #(
    parameter bit DUAL_BAND_CAPABLE = 1'b1
) (
    input wire logic CLOCK_IN,
    input wire logic SYS_RST_IN,
    input wire logic [15:0] S_AXI_AWADDR_IN,
    input wire logic S_AXI_AWVALID_IN,
    output logic S_AXI_AWREADY_OUT,
    input wire logic [31:0] S_AXI_WDATA_IN,
    input wire logic [3:0] S_AXI_WSTRB_IN,
    input wire logic S_AXI_WVALID_IN,
    output logic S_AXI_WREADY_OUT,
    output logic [1:0] S_AXI_BRESP_OUT,
    output logic S_AXI_BVALID_OUT,
    input wire logic S_AXI_BREADY_IN,
    input wire logic [15:0] S_AXI_ARADDR_IN,
    input wire logic S_AXI_ARVALID_IN,
    output logic S_AXI_ARREADY_OUT,
    output logic [31:0] S_AXI_RDATA_OUT,
    output logic [1:0] S_AXI_RRESP_OUT,
    output logic S_AXI_RVALID_OUT,
    input wire logic S_AXI_RREADY_IN,
    output logic CHA_DUAL_BAND_OUT,
    output logic CHB_DUAL_BAND_OUT,
    output logic CHA_REAL_OUT_OUT,
    output logic CHB_REAL_OUT_OUT,
    output logic CHA_SRC_ALT_OUT,
    output logic CHB_SRC_ALT_OUT,
    output logic CHA_CONV_PWR_OUT,
    output logic CHB_CONV_PWR_OUT,
    output logic [47:0] CHA_OSC_WORDS_OUT,
    output logic [47:0] CHB_OSC_WORDS_OUT
);
    typedef enum logic [2:0] {
        RD_IDLE = 3'b001,
        RD_LOOK = 3'b010,
        RD_RESP = 3'b100
    } ddcbn_rd_t;

    // Address decode: page select and register index, used twice
    function automatic logic [8:0] decode(input logic [15:0] a);
        logic [15:0] rel;
        rel = a - ddcbn_pkg::CHAN_A_BASE;
        decode = {rel[11], rel[9:2]};
        if (a[15:12] != ddcbn_pkg::CHAN_A_BASE[15:12] || rel[10]
            || a[1:0] != 2'h0)
            decode = {1'b0, 8'hff};
    endfunction

    logic aw_hold_q;
    logic [15:0] aw_addr_q;
    logic w_hold_q;
    logic [7:0] w_byte_q;
    logic w_lane_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic wr_en_a;
    logic wr_en_b;
    logic [8:0] wr_dec;
    logic [8:0] rd_dec;
    logic [15:0] ar_addr_q;
    ddcbn_rd_t rd_st_q;
    logic [7:0] rd_a;
    logic [7:0] rd_b;
    logic hit_a;
    logic hit_b;
    logic dual_a;
    logic dual_b;
    logic real_a;
    logic real_b;
    logic cross_a;
    logic cross_b;
    logic [47:0] words_a;
    logic [47:0] words_b;

    assign wr_dec = decode(aw_addr_q);
    assign rd_dec = decode(ar_addr_q);

    assign wr_en_a = aw_hold_q && w_hold_q && !bvalid_q && w_lane_q
                     && !wr_dec[8];
    assign wr_en_b = aw_hold_q && w_hold_q && !bvalid_q && w_lane_q
                     && wr_dec[8];

    // Write address channel, taken independent of write data
    always_ff @(posedge CLOCK_IN)
    begin
        if (SYS_RST_IN)
        begin
            aw_hold_q <= 1'b0;
            aw_addr_q <= 16'h0000;
        end
        else if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT)
        begin
            aw_hold_q <= 1'b1;
            aw_addr_q <= S_AXI_AWADDR_IN;
        end
        else if (bvalid_q && S_AXI_BREADY_IN)
            aw_hold_q <= 1'b0;
    end

    // Write data channel; only lane 0 carries register bits
    always_ff @(posedge CLOCK_IN)
    begin
        if (SYS_RST_IN)
        begin
            w_hold_q <= 1'b0;
            w_byte_q <= 8'h00;
            w_lane_q <= 1'b0;
        end
        else if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT)
        begin
            w_hold_q <= 1'b1;
            w_byte_q <= S_AXI_WDATA_IN[7:0];
            w_lane_q <= S_AXI_WSTRB_IN[0];
        end
        else if (bvalid_q && S_AXI_BREADY_IN)
            w_hold_q <= 1'b0;
    end

    // Ready while that channel's slot is empty
    always_ff @(posedge CLOCK_IN)
    begin
        if (SYS_RST_IN)
        begin
            S_AXI_AWREADY_OUT <= 1'b0;
            S_AXI_WREADY_OUT <= 1'b0;
        end
        else
        begin
            S_AXI_AWREADY_OUT <= !aw_hold_q
                && !(S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT)
                || (bvalid_q && S_AXI_BREADY_IN);
            S_AXI_WREADY_OUT <= !w_hold_q
                && !(S_AXI_WVALID_IN && S_AXI_WREADY_OUT)
                || (bvalid_q && S_AXI_BREADY_IN);
        end
    end

    // Write response once both halves are held
    always_ff @(posedge CLOCK_IN)
    begin
        if (SYS_RST_IN)
        begin
            bvalid_q <= 1'b0;
            bresp_q <= ddcbn_pkg::RESP_OKAY;
        end
        else if (aw_hold_q && w_hold_q && !bvalid_q)
        begin
            bvalid_q <= 1'b1;
            // Status word is read-only, so it errors as unmapped
            bresp_q <= (wr_dec[7:0] >= ddcbn_pkg::IDX_BAND_COUNT_SELECT
                && wr_dec[7:0] <= ddcbn_pkg::IDX_B1_OSC3_HIGH
                && wr_dec[7:0] != 8'h03 && wr_dec[7:0] != 8'h04)
                ? ddcbn_pkg::RESP_OKAY : ddcbn_pkg::RESP_SLVERR;
        end
        else if (bvalid_q && S_AXI_BREADY_IN)
            bvalid_q <= 1'b0;
    end
    assign S_AXI_BVALID_OUT = bvalid_q;
    assign S_AXI_BRESP_OUT = bresp_q;

    // Read sequencer: take address, wait for registered data, answer
    always_ff @(posedge CLOCK_IN)
    begin
        if (SYS_RST_IN)
        begin
            rd_st_q <= RD_IDLE;
            ar_addr_q <= 16'h0000;
            S_AXI_ARREADY_OUT <= 1'b0;
            S_AXI_RVALID_OUT <= 1'b0;
            S_AXI_RDATA_OUT <= 32'h0000_0000;
            S_AXI_RRESP_OUT <= ddcbn_pkg::RESP_OKAY;
        end
        else
        begin
            case (rd_st_q)
                RD_IDLE:
                begin
                    S_AXI_ARREADY_OUT <= !S_AXI_ARREADY_OUT;
                    if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT)
                    begin
                        ar_addr_q <= S_AXI_ARADDR_IN;
                        S_AXI_ARREADY_OUT <= 1'b0;
                        rd_st_q <= RD_LOOK;
                    end
                end
                RD_LOOK:
                begin
                    // Registered lookup in the channel bank takes a cycle
                    rd_st_q <= RD_RESP;
                end
                RD_RESP:
                begin
                    if (!S_AXI_RVALID_OUT)
                    begin
                        S_AXI_RVALID_OUT <= 1'b1;
                        S_AXI_RDATA_OUT <= {24'h000000,
                            rd_dec[8] ? rd_b : rd_a};
                        S_AXI_RRESP_OUT <= (rd_dec[8] ? hit_b : hit_a)
                            ? ddcbn_pkg::RESP_OKAY
                            : ddcbn_pkg::RESP_SLVERR;
                    end
                    else if (S_AXI_RREADY_IN)
                    begin
                        S_AXI_RVALID_OUT <= 1'b0;
                        rd_st_q <= RD_IDLE;
                    end
                end
                default: rd_st_q <= RD_IDLE;
            endcase
        end
    end

    ddcbn_chan_regs #(
        .DUAL_BAND_CAPABLE(DUAL_BAND_CAPABLE)
    ) u_chan_a (
        .clk_in(CLOCK_IN),
        .rst_in(SYS_RST_IN),
        .wr_en_in(wr_en_a),
        .wr_idx_in(wr_dec[7:0]),
        .wr_data_in(w_byte_q),
        .rd_idx_in(rd_dec[7:0]),
        .rd_data_out(rd_a),
        .rd_hit_out(hit_a),
        .dual_band_out(dual_a),
        .real_out_out(real_a),
        .cross_out(cross_a),
        .words_out(words_a)
    );

    // Channel B bank, same map at the second page
    ddcbn_chan_regs #(
        .DUAL_BAND_CAPABLE(DUAL_BAND_CAPABLE)
    ) u_chan_b (
        .clk_in(CLOCK_IN),
        .rst_in(SYS_RST_IN),
        .wr_en_in(wr_en_b),
        .wr_idx_in(wr_dec[7:0]),
        .wr_data_in(w_byte_q),
        .rd_idx_in(rd_dec[7:0]),
        .rd_data_out(rd_b),
        .rd_hit_out(hit_b),
        .dual_band_out(dual_b),
        .real_out_out(real_b),
        .cross_out(cross_b),
        .words_out(words_b)
    );

    // converter power follows who uses it
    ddcbn_route u_route (
        .clk_in(CLOCK_IN),
        .rst_in(SYS_RST_IN),
        .cross_a_in(cross_a),
        .cross_b_in(cross_b),
        .src_a_out(CHA_SRC_ALT_OUT),
        .src_b_out(CHB_SRC_ALT_OUT),
        .pwr_a_out(CHA_CONV_PWR_OUT),
        .pwr_b_out(CHB_CONV_PWR_OUT)
    );

    // Mode outputs retimed so each leaves from a flop
    always_ff @(posedge CLOCK_IN)
    begin
        if (SYS_RST_IN)
        begin
            CHA_DUAL_BAND_OUT <= 1'b0;
            CHB_DUAL_BAND_OUT <= 1'b0;
            CHA_REAL_OUT_OUT <= 1'b0;
            CHB_REAL_OUT_OUT <= 1'b0;
            CHA_OSC_WORDS_OUT <= 48'h0;
            CHB_OSC_WORDS_OUT <= 48'h0;
        end
        else
        begin
            CHA_DUAL_BAND_OUT <= dual_a;
            CHB_DUAL_BAND_OUT <= dual_b;
            CHA_REAL_OUT_OUT <= real_a;
            CHB_REAL_OUT_OUT <= real_b;
            CHA_OSC_WORDS_OUT <= words_a;
            CHB_OSC_WORDS_OUT <= words_b;
        end
    end

    // A write to osc1 low byte lands on the word two cycles later
    property p_osc1_low;
        @(posedge CLOCK_IN) disable iff (SYS_RST_IN)
        wr_en_a && wr_dec[7:0] == ddcbn_pkg::IDX_B1_OSC1_LOW
        |=> ##1 CHA_OSC_WORDS_OUT[7:0] == $past(w_byte_q, 2);
    endproperty
    a_osc1_low: assert property (p_osc1_low)
        else $error("osc1 low byte not stored");

    property p_osc2_high;
        @(posedge CLOCK_IN) disable iff (SYS_RST_IN)
        wr_en_b && wr_dec[7:0] == ddcbn_pkg::IDX_B1_OSC2_HIGH
        |=> ##1 CHB_OSC_WORDS_OUT[31:24] == $past(w_byte_q, 2);
    endproperty
    a_osc2_high: assert property (p_osc2_high)
        else $error("osc2 high byte not stored");

    property p_osc3_high;
        @(posedge CLOCK_IN) disable iff (SYS_RST_IN)
        wr_en_a && wr_dec[7:0] == ddcbn_pkg::IDX_B1_OSC3_HIGH
        |=> ##1 CHA_OSC_WORDS_OUT[47:40] == $past(w_byte_q, 2);
    endproperty
    a_osc3_high: assert property (p_osc3_high)
        else $error("osc3 high byte not stored");

    property p_dual;
        @(posedge CLOCK_IN) disable iff (SYS_RST_IN)
        wr_en_a && wr_dec[7:0] == ddcbn_pkg::IDX_BAND_COUNT_SELECT
        |=> ##1 CHA_DUAL_BAND_OUT == ($past(w_byte_q[0], 2)
                                      & DUAL_BAND_CAPABLE);
    endproperty
    a_dual: assert property (p_dual)
        else $error("dual band bit wrong");

    property p_real;
        @(posedge CLOCK_IN) disable iff (SYS_RST_IN)
        wr_en_b && wr_dec[7:0] == ddcbn_pkg::IDX_OUTPUT_FORMAT_SELECT
        |=> ##1 CHB_REAL_OUT_OUT == $past(w_byte_q[0], 2);
    endproperty
    a_real: assert property (p_real)
        else $error("real output bit wrong");

    property p_route;
        @(posedge CLOCK_IN) disable iff (SYS_RST_IN)
        wr_en_a && wr_dec[7:0] == ddcbn_pkg::IDX_INPUT_SOURCE_SELECT
        |=> ##1 CHA_SRC_ALT_OUT == $past(w_byte_q[0], 2);
    endproperty
    a_route: assert property (p_route)
        else $error("input routing bit wrong");

    // Both DDCs on converter B leaves converter A unused
    property p_power;
        @(posedge CLOCK_IN) disable iff (SYS_RST_IN)
        CHA_SRC_ALT_OUT && !CHB_SRC_ALT_OUT |-> !CHA_CONV_PWR_OUT;
    endproperty
    a_power: assert property (p_power)
        else $error("unused converter still powered");

    sequence s_wr_done;
        aw_hold_q && w_hold_q && !bvalid_q;
    endsequence
    // An aligned write into the second page must land in channel B only
    property p_page;
        @(posedge CLOCK_IN) disable iff (SYS_RST_IN)
        s_wr_done ##0 (w_lane_q && aw_addr_q[1:0] == 2'h0
            && aw_addr_q[15:10] == ddcbn_pkg::CHAN_B_BASE[15:10])
        |-> wr_en_b && !wr_en_a;
    endproperty
    a_page: assert property (p_page)
        else $error("write hit both pages");

    property p_bresp;
        @(posedge CLOCK_IN) disable iff (SYS_RST_IN)
        s_wr_done |=> S_AXI_BVALID_OUT;
    endproperty
    a_bresp: assert property (p_bresp)
        else $error("write response late");
endmodule // ddcbn_top

// File: dv/ddcbn_host.sv
// Host controller model: AXI4-Lite master issuing register accesses
`timescale 1ns/1ps
module ddcbn_host (
    input wire logic clk_in,
    output logic [15:0] awaddr_out,
    output logic awvalid_out,
    input wire logic awready_in,
    output logic [31:0] wdata_out,
    output logic [3:0] wstrb_out,
    output logic wvalid_out,
    input wire logic wready_in,
    input wire logic [1:0] bresp_in,
    input wire logic bvalid_in,
    output logic bready_out,
    output logic [15:0] araddr_out,
    output logic arvalid_out,
    input wire logic arready_in,
    input wire logic [31:0] rdata_in,
    input wire logic [1:0] rresp_in,
    input wire logic rvalid_in,
    output logic rready_out
);
    // Idle bus at time zero
    initial
    begin
        awaddr_out = 16'h0000;
        awvalid_out = 1'b0;
        wdata_out = 32'h00000000;
        wstrb_out = 4'hf;
        wvalid_out = 1'b0;
        bready_out = 1'b0;
        araddr_out = 16'h0000;
        arvalid_out = 1'b0;
        rready_out = 1'b0;
    end

    function automatic logic [15:0] addr_of(input bit ch,
        input logic [7:0] idx);
        return (ch ? ddcbn_pkg::CHAN_B_BASE : ddcbn_pkg::CHAN_A_BASE)
            + {6'h00, idx, 2'h0};
    endfunction

    // Write; released payload is inverted so stale values never match
    task automatic wr(input bit ch, input logic [7:0] idx,
        input logic [7:0] d, output logic [1:0] r);
        bit aw_ok;
        bit w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge clk_in);
        awaddr_out <= addr_of(ch, idx);
        awvalid_out <= 1'b1;
        wdata_out <= {24'h000000, d};
        wvalid_out <= 1'b1;
        bready_out <= 1'b1;
        while (!(aw_ok && w_ok))
        begin
            @(posedge clk_in);
            if (awvalid_out && awready_in)
            begin
                aw_ok = 1'b1;
                awvalid_out <= 1'b0;
                awaddr_out <= ~awaddr_out;
            end
            if (wvalid_out && wready_in)
            begin
                w_ok = 1'b1;
                wvalid_out <= 1'b0;
                wdata_out <= ~wdata_out;
            end
        end
        do
            @(posedge clk_in);
        while (!bvalid_in);
        r = bresp_in;
        bready_out <= 1'b0;
    endtask

    // Read; waits for the answer however late it comes
    task automatic rd(input bit ch, input logic [7:0] idx,
        output logic [31:0] d, output logic [1:0] r);
        @(posedge clk_in);
        araddr_out <= addr_of(ch, idx);
        arvalid_out <= 1'b1;
        rready_out <= 1'b1;
        do
            @(posedge clk_in);
        while (!arready_in);
        arvalid_out <= 1'b0;
        araddr_out <= ~araddr_out;
        do
            @(posedge clk_in);
        while (!rvalid_in);
        d = rdata_in;
        r = rresp_in;
        rready_out <= 1'b0;
    endtask
endmodule // ddcbn_host

// File: dv/tb_ddc_band_output_nco_config.sv
// Self-checking bench for the DDC configuration register bank
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
    begin \
        n_checks++; \
        if ((got) !== (exp)) \
        begin \
            err_count++; \
            $display("mismatch %s exp %h got %h", nm, exp, got); \
        end \
    end
module tb_ddc_band_output_nco_config;
    logic clk, rst;
    logic [15:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rdv;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rsp;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic dual_a, dual_b, real_a, real_b, alt_a, alt_b, pwr_a, pwr_b;
    logic [47:0] words_a, words_b;
    int err_count, n_checks;
    localparam logic [7:0] IDX_TAB [9] = '{
        ddcbn_pkg::IDX_BAND_COUNT_SELECT, ddcbn_pkg::IDX_OUTPUT_FORMAT_SELECT,
        ddcbn_pkg::IDX_INPUT_SOURCE_SELECT, ddcbn_pkg::IDX_B1_OSC1_LOW,
        ddcbn_pkg::IDX_B1_OSC1_HIGH, ddcbn_pkg::IDX_B1_OSC2_LOW,
        ddcbn_pkg::IDX_B1_OSC2_HIGH, ddcbn_pkg::IDX_B1_OSC3_LOW,
        ddcbn_pkg::IDX_B1_OSC3_HIGH};

    ddcbn_top dut_u (.CLOCK_IN(clk), .SYS_RST_IN(rst),
        .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid),
        .S_AXI_AWREADY_OUT(awready), .S_AXI_WDATA_IN(wdata),
        .S_AXI_WSTRB_IN(wstrb), .S_AXI_WVALID_IN(wvalid),
        .S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp),
        .S_AXI_BVALID_OUT(bvalid), .S_AXI_BREADY_IN(bready),
        .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid),
        .S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata),
        .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rvalid),
        .S_AXI_RREADY_IN(rready), .CHA_DUAL_BAND_OUT(dual_a),
        .CHB_DUAL_BAND_OUT(dual_b), .CHA_REAL_OUT_OUT(real_a),
        .CHB_REAL_OUT_OUT(real_b), .CHA_SRC_ALT_OUT(alt_a),
        .CHB_SRC_ALT_OUT(alt_b), .CHA_CONV_PWR_OUT(pwr_a),
        .CHB_CONV_PWR_OUT(pwr_b), .CHA_OSC_WORDS_OUT(words_a),
        .CHB_OSC_WORDS_OUT(words_b));

    ddcbn_host host_u (.clk_in(clk), .awaddr_out(awaddr),
        .awvalid_out(awvalid), .awready_in(awready), .wdata_out(wdata),
        .wstrb_out(wstrb), .wvalid_out(wvalid), .wready_in(wready),
        .bresp_in(bresp), .bvalid_in(bvalid), .bready_out(bready),
        .araddr_out(araddr), .arvalid_out(arvalid), .arready_in(arready),
        .rdata_in(rdata), .rresp_in(rresp), .rvalid_in(rvalid),
        .rready_out(rready));

    // Free-running 20 MHz clock
    initial clk = 1'b0;
    always #25 clk = ~clk;

    // Byte pattern per channel: control bits set, osc bytes distinct
    function automatic logic [7:0] val(input bit ch, input int i);
        return (i < 3) ? 8'h01 : {(ch ? 4'hb : 4'ha), i[3:0]};
    endfunction

    // Verdict and end of run
    task automatic results();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Outputs settle two edges after a write completes
    task automatic chk_outs(input logic [7:0] m, input logic [95:0] w);
        logic [7:0] md;
        repeat (2) @(posedge clk);
        md = {dual_a, dual_b, real_a, real_b, alt_a, alt_b, pwr_a, pwr_b};
        `CHK("modes", m, md)
        `CHK("words", w, {words_a, words_b})
    endtask

    // Main sequence
    initial
    begin
        err_count = 0;
        n_checks = 0;
        rst = 1'b1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        chk_outs(8'h03, 96'h0);
        // Reset values read back zero on both pages
        for (int c = 0; c < 2; c++)
            for (int i = 0; i < 9; i++)
            begin
                host_u.rd(c[0], IDX_TAB[i], rdv, rsp);
                `CHK("reset value", 32'h0, rdv)
                `CHK("read resp", ddcbn_pkg::RESP_OKAY, rsp)
            end
        // Fill every register on both channels
        for (int c = 0; c < 2; c++)
            for (int i = 0; i < 9; i++)
            begin
                host_u.wr(c[0], IDX_TAB[i], val(c[0], i), rsp);
                `CHK("write resp", ddcbn_pkg::RESP_OKAY, rsp)
            end
        chk_outs(8'hff, {48'ha8a7a6a5a4a3, 48'hb8b7b6b5b4b3});
        for (int c = 0; c < 2; c++)
        begin
            for (int i = 0; i < 9; i++)
            begin
                host_u.rd(c[0], IDX_TAB[i], rdv, rsp);
                `CHK("readback", {24'h0, val(c[0], i)}, rdv)
            end
            host_u.rd(c[0], ddcbn_pkg::IDX_MODE_STATUS, rdv, rsp);
            `CHK("status", 32'h7, rdv)
        end
        // Both DDCs on converter B: converter A may power down
        host_u.wr(1'b1, ddcbn_pkg::IDX_INPUT_SOURCE_SELECT, 8'h00, rsp);
        chk_outs(8'hf9, {48'ha8a7a6a5a4a3, 48'hb8b7b6b5b4b3});
        // Channel A back to single band, complex, own input
        host_u.wr(1'b0, ddcbn_pkg::IDX_BAND_COUNT_SELECT, 8'h00, rsp);
        host_u.wr(1'b0, ddcbn_pkg::IDX_OUTPUT_FORMAT_SELECT, 8'h00, rsp);
        host_u.wr(1'b0, ddcbn_pkg::IDX_INPUT_SOURCE_SELECT, 8'h00, rsp);
        host_u.wr(1'b0, ddcbn_pkg::IDX_B1_OSC2_LOW, 8'h5a, rsp);
        chk_outs(8'h53, {48'ha8a7a65aa4a3, 48'hb8b7b6b5b4b3});
        // Unmapped and read-only places refuse without side effects
        host_u.wr(1'b0, 8'h03, 8'h01, rsp);
        `CHK("unmapped wr", ddcbn_pkg::RESP_SLVERR, rsp)
        host_u.wr(1'b1, ddcbn_pkg::IDX_MODE_STATUS, 8'h07, rsp);
        `CHK("status wr", ddcbn_pkg::RESP_SLVERR, rsp)
        host_u.rd(1'b0, 8'h03, rdv, rsp);
        `CHK("unmapped rd", ddcbn_pkg::RESP_SLVERR, rsp)
        `CHK("unmapped data", 32'h0, rdv)
        chk_outs(8'h53, {48'ha8a7a65aa4a3, 48'hb8b7b6b5b4b3});
        results();
    end

    // Watchdog: tests need well under 2000 cycles
    initial
    begin
        #(50 * 20000);
        err_count++;
        results();
    end
endmodule // tb_ddc_band_output_nco_config
